// ===== logic/rat_top.v
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`include "rat_defs.vh"

module rat_top #(
    parameter TICK_CYCLES = `RAT_TICK_CYC
) (
    input wire mclk_i, // System clock, 125 MHz.
    input wire srst_i, // Synchronous reset.
    input wire [7:0] s_axi_awaddr_i, // Write address.
    input wire s_axi_awvalid_i, // Write address valid.
    output wire s_axi_awready_o, // Write address ready.
    input wire [31:0] s_axi_wdata_i, // Write data.
    input wire [3:0] s_axi_wstrb_i, // Write strobes.
    input wire s_axi_wvalid_i, // Write data valid.
    output wire s_axi_wready_o, // Write data ready.
    output reg [1:0] s_axi_bresp_o, // Write response.
    output reg s_axi_bvalid_o, // Write response valid.
    input wire s_axi_bready_i, // Write response ready.
    input wire [7:0] s_axi_araddr_i, // Read address.
    input wire s_axi_arvalid_i, // Read address valid.
    output wire s_axi_arready_o, // Read address ready.
    output reg [31:0] s_axi_rdata_o, // Read data.
    output reg [1:0] s_axi_rresp_o, // Read response.
    output reg s_axi_rvalid_o, // Read data valid.
    input wire s_axi_rready_i, // Read data ready.
    input wire [15:0] pv1_i, // Loop one variable, same clock.
    input wire [15:0] pv2_i, // Loop two variable, same clock.
    output wire out1_o, // Switching output one.
    output wire out2_o, // Switching output two.
    output reg tune_msg_o, // Upper display shows the tune indicator.
    output reg pv_shown_o, // Upper display shows the variable.
    output reg tuning_o // Tune in progress.
);
    localparam integer TICK_LAST = TICK_CYCLES - 1;
    localparam integer BLINK_LAST = `RAT_BLINK_TICKS - 1;

    reg [11:0] ctrl;
    reg [15:0] period;
    reg [31:0] pidres;
    reg [31:0] manual;
    reg [31:0] setpt;
    reg [31:0] tunecfg;
    reg [31:0] limits;
    reg [31:0] dertime;
    reg done_f;
    reg abort_f;
    reg refused_f;
    reg tun;
    reg tsel;
    reg tstart;
    reg [15:0] hold;
    reg [15:0] amp_l;
    reg [31:0] res_per [0:1];
    reg [31:0] res_int [0:1];
    reg [31:0] res_der [0:1];
    reg [31:0] res_gain [0:1];

    reg [23:0] pre;
    reg tick;
    reg [9:0] blink_cnt;
    reg blink;
    reg [31:0] rd_mux;

    wire id_busy;
    wire [15:0] id_duty;
    wire id_done;
    wire id_abort;
    wire [31:0] id_per;
    wire [15:0] id_pp;
    wire [1:0] sw;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    function [15:0] half;
        input [31:0] w;
        input s;
        begin
            half = s ? w[31:16] : w[15:0];
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            case (a)
                `RAT_A_CTRL, `RAT_A_PERIOD, `RAT_A_PIDRES, `RAT_A_MANUAL,
                `RAT_A_SETPT, `RAT_A_TUNECFG, `RAT_A_LIMITS, `RAT_A_DERTIME,
                `RAT_A_STATUS, `RAT_A_RES1_PER, `RAT_A_RES1_INT, `RAT_A_RES1_DER,
                `RAT_A_RES1_GAIN, `RAT_A_RES2_PER, `RAT_A_RES2_INT, `RAT_A_RES2_DER,
                `RAT_A_RES2_GAIN: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
    wire rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_arready_o = rd_go;

    wire sel = ctrl[`RAT_C_SEL];
    wire req = ctrl[`RAT_C_DEMAND] | ctrl[`RAT_C_STARTUP];
    wire pid_sel = sel ? ctrl[`RAT_C_PID2] : ctrl[`RAT_C_PID1];
    wire man_sel = sel ? ctrl[`RAT_C_MAN2] : ctrl[`RAT_C_MAN1];
    wire man_t = tsel ? ctrl[`RAT_C_MAN2] : ctrl[`RAT_C_MAN1];
    wire allowed = ctrl[`RAT_C_DUAL] & pid_sel & ~ctrl[`RAT_C_SPPROG];
    wire try_go = req & ~tun;
    wire start = try_go & allowed;
    wire refuse = try_go & ~allowed;
    wire [15:0] cur_sel = man_sel ? half(manual, sel) : half(pidres, sel);

    // Start-up tune swings the full output range; demand tune swings about the present output.
    wire [15:0] hold_in = tun ? hold : (ctrl[`RAT_C_STARTUP] ? `RAT_HALF : cur_sel);
    wire [15:0] amp_in = tun ? amp_l : (ctrl[`RAT_C_STARTUP] ? `RAT_HALF : tunecfg[15:0]);

    wire der_zero = half(dertime, tsel) == 16'h0000;
    wire [37:0] pi_prod = id_per * 6'd53;
    wire [31:0] ctrl_wr = merge({20'h00000, ctrl}, s_axi_wdata_i, s_axi_wstrb_i);
    wire [31:0] period_wr = merge({16'h0000, period}, s_axi_wdata_i, s_axi_wstrb_i);

    rat_ident u_ident (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .start_i(start),
        .cancel_i(ctrl[`RAT_C_CANCEL]),
        .abort_en_i(~tstart),
        .direct_i(tsel ? ctrl[`RAT_C_DIR2] : ctrl[`RAT_C_DIR1]),
        .pv_i(tsel ? pv2_i : pv1_i),
        .sp_i(half(setpt, tsel)),
        .hyst_i(tunecfg[31:16]),
        .hold_i(hold_in),
        .amp_i(amp_in),
        .upper_i(limits[31:16]),
        .lower_i(limits[15:0]),
        .busy_o(id_busy),
        .duty_o(id_duty),
        .done_o(id_done),
        .abort_o(id_abort),
        .period_o(id_per),
        .pp_o(id_pp)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_loop
            wire man = ctrl[`RAT_C_MAN1 + g];
            wire [15:0] base = man ? half(manual, g == 1) : half(pidres, g == 1);
            wire [15:0] duty = (tun && id_busy && (tsel == (g == 1))) ? id_duty : base;
            rat_tprop u_tp (
                .mclk_i(mclk_i),
                .srst_i(srst_i),
                .tick_i(tick),
                .period_i(period),
                .duty_i(duty),
                .switch_o(sw[g])
            );
        end
    endgenerate

    assign out1_o = sw[0];
    assign out2_o = sw[1];

    always @* begin
        case (s_axi_araddr_i)
            `RAT_A_CTRL: rd_mux = {20'h00000, ctrl};
            `RAT_A_PERIOD: rd_mux = {16'h0000, period};
            `RAT_A_PIDRES: rd_mux = pidres;
            `RAT_A_MANUAL: rd_mux = manual;
            `RAT_A_SETPT: rd_mux = setpt;
            `RAT_A_TUNECFG: rd_mux = tunecfg;
            `RAT_A_LIMITS: rd_mux = limits;
            `RAT_A_DERTIME: rd_mux = dertime;
            `RAT_A_STATUS: rd_mux = {26'h0000000, tstart & tun, refused_f, abort_f, done_f, tsel, tun};
            `RAT_A_RES1_PER: rd_mux = res_per[0];
            `RAT_A_RES1_INT: rd_mux = res_int[0];
            `RAT_A_RES1_DER: rd_mux = res_der[0];
            `RAT_A_RES1_GAIN: rd_mux = res_gain[0];
            `RAT_A_RES2_PER: rd_mux = res_per[1];
            `RAT_A_RES2_INT: rd_mux = res_int[1];
            `RAT_A_RES2_DER: rd_mux = res_der[1];
            `RAT_A_RES2_GAIN: rd_mux = res_gain[1];
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            pre <= 24'h000000;
            tick <= 1'b0;
            blink_cnt <= 10'h000;
            blink <= 1'b0;
            tune_msg_o <= 1'b0;
            pv_shown_o <= 1'b1;
            tuning_o <= 1'b0;
        end else begin
            if (pre == TICK_LAST[23:0]) begin
                pre <= 24'h000000;
                tick <= 1'b1;
            end else begin
                pre <= pre + 24'h000001;
                tick <= 1'b0;
            end
            if (~tun) begin
                blink_cnt <= 10'h000;
                blink <= 1'b1;
            end else if (tick) begin
                if (blink_cnt == BLINK_LAST[9:0]) begin
                    blink_cnt <= 10'h000;
                    blink <= ~blink;
                end else begin
                    blink_cnt <= blink_cnt + 10'h001;
                end
            end
            tune_msg_o <= tun & blink;
            pv_shown_o <= ~tun | (~tstart & ~blink);
            tuning_o <= tun;
        end
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'b00;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= 2'b00;
            s_axi_rdata_o <= 32'h00000000;
        end else begin
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= mapped(s_axi_awaddr_i) ? 2'b00 : 2'b10;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= mapped(s_axi_araddr_i) ? 2'b00 : 2'b10;
                s_axi_rdata_o <= rd_mux;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl <= `RAT_RST_CTRL;
            period <= `RAT_RST_PERIOD;
            pidres <= 32'h00000000;
            manual <= 32'h00000000;
            setpt <= 32'h00000000;
            tunecfg <= `RAT_RST_TUNECFG;
            limits <= `RAT_RST_LIMITS;
            dertime <= 32'h00000000;
            done_f <= 1'b0;
            abort_f <= 1'b0;
            refused_f <= 1'b0;
            tun <= 1'b0;
            tsel <= 1'b0;
            tstart <= 1'b0;
            hold <= 16'h0000;
            amp_l <= 16'h0000;
            res_per[0] <= 32'h00000000;
            res_per[1] <= 32'h00000000;
            res_int[0] <= 32'h00000000;
            res_int[1] <= 32'h00000000;
            res_der[0] <= 32'h00000000;
            res_der[1] <= 32'h00000000;
            res_gain[0] <= 32'h00000000;
            res_gain[1] <= 32'h00000000;
        end else begin
            ctrl[`RAT_C_CANCEL] <= 1'b0;
            if (wr_go) begin
                case (s_axi_awaddr_i)
                    `RAT_A_CTRL: ctrl <= ctrl_wr[11:0];
                    `RAT_A_PERIOD: period <= period_wr[15:0];
                    `RAT_A_PIDRES: pidres <= merge(pidres, s_axi_wdata_i, s_axi_wstrb_i);
                    `RAT_A_MANUAL: manual <= merge(manual, s_axi_wdata_i, s_axi_wstrb_i);
                    `RAT_A_SETPT: setpt <= merge(setpt, s_axi_wdata_i, s_axi_wstrb_i);
                    `RAT_A_TUNECFG: tunecfg <= merge(tunecfg, s_axi_wdata_i, s_axi_wstrb_i);
                    `RAT_A_LIMITS: limits <= merge(limits, s_axi_wdata_i, s_axi_wstrb_i);
                    `RAT_A_DERTIME: dertime <= merge(dertime, s_axi_wdata_i, s_axi_wstrb_i);
                    `RAT_A_STATUS: begin
                        if (s_axi_wstrb_i[0] & s_axi_wdata_i[`RAT_S_DONE]) done_f <= 1'b0;
                        if (s_axi_wstrb_i[0] & s_axi_wdata_i[`RAT_S_ABORT]) abort_f <= 1'b0;
                        if (s_axi_wstrb_i[0] & s_axi_wdata_i[`RAT_S_REFUSED]) refused_f <= 1'b0;
                    end
                    default: begin
                    end
                endcase
            end

            // Hardware updates below come after the bus write so they win over it, whether they set or clear.
            if (start) begin
                tun <= 1'b1;
                tsel <= sel;
                tstart <= ctrl[`RAT_C_STARTUP];
                hold <= hold_in;
                amp_l <= amp_in;
            end
            if (refuse) begin
                ctrl[`RAT_C_DEMAND] <= 1'b0;
                ctrl[`RAT_C_STARTUP] <= 1'b0;
                refused_f <= 1'b1;
            end

            if (tun & (id_done | id_abort)) begin
                tun <= 1'b0;
                ctrl[`RAT_C_DEMAND] <= 1'b0;
                ctrl[`RAT_C_STARTUP] <= 1'b0;
            end
            if (tun & id_abort) begin
                abort_f <= 1'b1;
                if (~man_t & ~tstart) begin
                    if (tsel) pidres[31:16] <= hold;
                    else pidres[15:0] <= hold;
                end
            end
            if (tun & id_done) begin
                done_f <= 1'b1;
                if (tsel) ctrl[`RAT_C_MAN2] <= 1'b0;
                else ctrl[`RAT_C_MAN1] <= 1'b0;
                res_per[tsel] <= id_per;
                // PI only when derivative is zero
                res_der[tsel] <= der_zero ? 32'h00000000 : {3'b000, id_per[31:3]};
                res_int[tsel] <= der_zero ? pi_prod[37:6] : {1'b0, id_per[31:1]};
                res_gain[tsel] <= {amp_l, id_pp};
            end
        end
    end
endmodule // rat_top

// ===== logic/rat_defs.vh
`ifndef RAT_DEFS_VH
`define RAT_DEFS_VH

// Register byte offsets.
`define RAT_A_CTRL 8'h00
`define RAT_A_PERIOD 8'h04
`define RAT_A_PIDRES 8'h08
`define RAT_A_MANUAL 8'h0C
`define RAT_A_SETPT 8'h10
`define RAT_A_TUNECFG 8'h14
`define RAT_A_LIMITS 8'h18
`define RAT_A_DERTIME 8'h1C
`define RAT_A_STATUS 8'h20
`define RAT_A_RES1_PER 8'h30
`define RAT_A_RES1_INT 8'h34
`define RAT_A_RES1_DER 8'h38
`define RAT_A_RES1_GAIN 8'h3C
`define RAT_A_RES2_PER 8'h40
`define RAT_A_RES2_INT 8'h44
`define RAT_A_RES2_DER 8'h48
`define RAT_A_RES2_GAIN 8'h4C

// Control register fields.
`define RAT_C_DUAL 0
`define RAT_C_PID1 1
`define RAT_C_PID2 2
`define RAT_C_SPPROG 3
`define RAT_C_SEL 4
`define RAT_C_DEMAND 5
`define RAT_C_STARTUP 6
`define RAT_C_DIR1 7
`define RAT_C_DIR2 8
`define RAT_C_MAN1 9
`define RAT_C_MAN2 10
`define RAT_C_CANCEL 11

// Status register fields.
`define RAT_S_DONE 2
`define RAT_S_ABORT 3
`define RAT_S_REFUSED 4

// Reset values.
`define RAT_RST_CTRL 12'h007
`define RAT_RST_PERIOD 16'h03E8
`define RAT_RST_TUNECFG 32'h000A0064
`define RAT_RST_LIMITS 32'h270FFC19

// Output scale in tenths of a percent.
`define RAT_FULL 16'h03E8
`define RAT_HALF 16'h01F4

// Timing.
`define RAT_CLK_NS 8
`define RAT_TICK_NS 1000000
`define RAT_TICK_CYC (`RAT_TICK_NS / `RAT_CLK_NS)
`define RAT_BLINK_MS 500
`define RAT_BLINK_TICKS (`RAT_BLINK_MS * 1000000 / `RAT_TICK_NS)
`define RAT_TUNE_OSC 4'h3

`endif

// ===== logic/rat_tprop.v
`include "rat_defs.vh"

module rat_tprop (
    input wire mclk_i, // System clock.
    input wire srst_i, // Synchronous reset.
    input wire tick_i, // One-millisecond tick.
    input wire [15:0] period_i, // Period in ms.
    input wire [15:0] duty_i, // On share in tenths of a percent.
    output reg switch_o // Switching output.
);
    reg [15:0] pos;
    reg [15:0] per_l;
    reg [9:0] duty_l;
    wire [25:0] lhs = pos * 10'd1000;
    wire [25:0] rhs = duty_l * per_l;

    // Period and duty are taken only at a period boundary, so the period stays fixed.
    always @(posedge mclk_i) begin
        if (srst_i) begin
            pos <= 16'h0000;
            per_l <= `RAT_RST_PERIOD;
            duty_l <= 10'h000;
            switch_o <= 1'b0;
        end else begin
            if (tick_i) begin
                if (per_l == 16'h0000 || pos >= per_l - 16'h0001) begin
                    pos <= 16'h0000;
                    per_l <= period_i;
                    duty_l <= (duty_i > `RAT_FULL) ? 10'h3E8 : duty_i[9:0];
                end else begin
                    pos <= pos + 16'h0001;
                end
            end
            switch_o <= (per_l != 16'h0000) && (lhs < rhs);
        end
    end
endmodule // rat_tprop

// ===== logic/rat_ident.v
`include "rat_defs.vh"

module rat_ident (
    input wire mclk_i, // System clock.
    input wire srst_i, // Synchronous reset.
    input wire start_i, // Start pulse.
    input wire cancel_i, // Software cancel.
    input wire abort_en_i, // Safety limits armed.
    input wire direct_i, // Direct action.
    input wire [15:0] pv_i, // Process variable.
    input wire [15:0] sp_i, // Setpoint.
    input wire [15:0] hyst_i, // Hysteresis.
    input wire [15:0] hold_i, // Centre output level.
    input wire [15:0] amp_i, // Step amplitude.
    input wire [15:0] upper_i, // Upper safety limit.
    input wire [15:0] lower_i, // Lower safety limit.
    output reg busy_o, // Tune running.
    output reg [15:0] duty_o, // Tune output level.
    output reg done_o, // Finished pulse.
    output reg abort_o, // Aborted pulse.
    output reg [31:0] period_o, // Oscillation period in cycles.
    output reg [15:0] pp_o // Peak to peak of the variable.
);
    wire signed [16:0] pv = {pv_i[15], pv_i};
    wire signed [16:0] sp = {sp_i[15], sp_i};
    wire signed [16:0] hy = {hyst_i[15], hyst_i};
    wire signed [16:0] err = direct_i ? pv - sp : sp - pv;
    wire go_up = err > hy;
    wire go_dn = err < -hy;
    wire trip = abort_en_i & (($signed(pv_i) > $signed(upper_i)) | ($signed(pv_i) < $signed(lower_i)));
    wire [16:0] up_sum = {1'b0, hold_i} + {1'b0, amp_i};
    wire [15:0] up_lvl = (up_sum > {1'b0, `RAT_FULL}) ? `RAT_FULL : up_sum[15:0];
    wire [15:0] dn_lvl = (amp_i > hold_i) ? 16'h0000 : hold_i - amp_i;
    reg high;
    reg seen;
    reg [3:0] osc;
    reg [31:0] cnt;
    reg signed [15:0] pmax;
    reg signed [15:0] pmin;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            busy_o <= 1'b0;
            duty_o <= 16'h0000;
            done_o <= 1'b0;
            abort_o <= 1'b0;
            period_o <= 32'h00000000;
            pp_o <= 16'h0000;
            high <= 1'b0;
            seen <= 1'b0;
            osc <= 4'h0;
            cnt <= 32'h00000000;
            pmax <= 16'h0000;
            pmin <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            abort_o <= 1'b0;
            if (start_i) begin
                busy_o <= 1'b1;
                high <= 1'b1;
                seen <= 1'b0;
                osc <= 4'h0;
                cnt <= 32'h00000000;
                pmax <= pv_i;
                pmin <= pv_i;
                duty_o <= up_lvl;
            end else if (busy_o) begin
                cnt <= cnt + 32'h00000001;
                if ($signed(pv_i) > pmax) pmax <= pv_i;
                if ($signed(pv_i) < pmin) pmin <= pv_i;
                if (trip | cancel_i) begin
                    busy_o <= 1'b0;
                    abort_o <= 1'b1;
                end else if (~high & go_up) begin
                    high <= 1'b1;
                    duty_o <= up_lvl;
                    cnt <= 32'h00000000;
                    seen <= 1'b1;
                    pmax <= pv_i;
                    pmin <= pv_i;
                    if (seen) begin
                        period_o <= cnt;
                        pp_o <= pmax - pmin;
                        osc <= osc + 4'h1;
                        if (osc == `RAT_TUNE_OSC - 4'h1) begin
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                        end
                    end
                end else if (high & go_dn) begin
                    high <= 1'b0;
                    duty_o <= dn_lvl;
                end
            end
        end
    end
endmodule // rat_ident

// ===== test/rat_chk.sv
module rat_chk (
    input wire logic mclk_i, // Clock.
    input wire logic srst_i, // Reset.
    input wire logic s_axi_awready_o, // Taken.
    input wire logic [1:0] s_axi_bresp_o, // Code.
    input wire logic s_axi_bvalid_o, // Valid.
    input wire logic s_axi_bready_i, // Ready.
    input wire logic [7:0] s_axi_araddr_i, // Address.
    input wire logic s_axi_arvalid_i, // Valid.
    input wire logic s_axi_arready_o, // Ready.
    input wire logic [31:0] s_axi_rdata_o, // Data.
    input wire logic [1:0] s_axi_rresp_o, // Code.
    input wire logic s_axi_rvalid_o, // Valid.
    input wire logic s_axi_rready_i, // Ready.
    input wire logic tune_msg_o, // Indicator.
    input wire logic pv_shown_o, // Variable.
    input wire logic tuning_o // Busy.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    wr_answer_a: assert property (s_axi_awready_o |=> s_axi_bvalid_o)
        else $error("write not answered");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read not answered");
    rd_guard_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while busy");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped");
    rd_unmap_a: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h4C
        |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0) else $error("unmapped read");
    disp_excl_a: assert property (!(tune_msg_o && pv_shown_o))
        else $error("indicator and variable together");
    disp_end_a: assert property ($fell(tuning_o) ##2 !tuning_o |-> !tune_msg_o && pv_shown_o)
        else $error("indicator left after tune");
endmodule // rat_chk

bind rat_top rat_chk u_chk (.mclk_i, .srst_i, .s_axi_awready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .tune_msg_o, .pv_shown_o, .tuning_o);

// ===== test/rat_plant.sv
module rat_plant #(
    parameter logic [15:0] BASE = 16'h0100
) (
    input wire logic mclk_i, // Clock.
    input wire logic srst_i, // Reset.
    input wire logic hold_i, // Recentre.
    input wire logic out1_i, // Switch one.
    input wire logic out2_i, // Switch two.
    output logic [15:0] pv1_o, // Variable one.
    output logic [15:0] pv2_o // Variable two.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [15:0] acc1 = 16'sh0, acc2 = 16'sh0;
    always @(posedge mclk_i) begin
        acc1 <= (srst_i || hold_i) ? 16'sh0 : acc1 + (out1_i ? 16'sh1 : -16'sh1);
        acc2 <= (srst_i || hold_i) ? 16'sh0 : acc2 + (out2_i ? 16'sh1 : -16'sh1);
    end
    // The variable ramps up while the switch is on and down while it is off, scaled by an eighth, so ripple inside one period stays small.
    assign pv1_o = BASE + 16'(acc1 >>> 3);
    assign pv2_o = BASE + 16'(acc2 >>> 3);
endmodule // rat_plant

// ===== test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'h0, srst_i = 1'h1, hold = 1'h1;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    logic [15:0] pv1_i, pv2_i;
    logic out1_o, out2_o, tune_msg_o, pv_shown_o, tuning_o;
    logic [5:0] w;
    int n_mismatch = 0, n_tests = 0, c1, c2;
    logic [63:0] rows [4] = '{64'h0004_0000_01F4_0200, 64'h0004_00FA_03E8_0401,
        64'h0005_02BC_0000_0004, 64'h0002_03E8_012C_0102};
    logic [39:0] rst_rows [4] = '{40'h00_00000007, 40'h04_000003E8, 40'h14_000A0064, 40'h18_270FFC19};
    logic [15:0] ref_rows [4] = '{16'h002F, 16'h0025, 16'h0026, 16'h0033};

    rat_top #(.TICK_CYCLES(10)) DUT (.*);
    rat_plant PLANT (.mclk_i, .srst_i, .hold_i(hold), .out1_i(out1_o), .out2_i(out2_o), .pv1_o(pv1_i),
        .pv2_o(pv2_i));
    always #4 mclk_i = ~mclk_i;
    assign w = {!tuning_o, tuning_o, s_axi_rvalid_o, s_axi_arready_o, s_axi_bvalid_o, s_axi_awready_o};

    task end_sim;
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wait_hi(input int k);
        int t;
        for (t = 0; t < 30000; t++) begin
            @(posedge mclk_i);
            if (w[k] === 1'h1)
                break;
        end
        if (t == 30000) begin
            n_mismatch++;
            end_sim;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        wait_hi(0);
        s_axi_awvalid_i <= 1'h0;
        s_axi_wvalid_i <= 1'h0;
        wait_hi(1);
        s_axi_bready_i <= 1'h1;
        @(posedge mclk_i);
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        wait_hi(2);
        s_axi_arvalid_i <= 1'h0;
        wait_hi(3);
        s_axi_rready_i <= 1'h1;
        @(posedge mclk_i);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'h0;
    endtask
    task chk_reset;
        foreach (rst_rows[k]) begin
            rd(rst_rows[k][39:32]);
            chk(d, rst_rows[k][31:0]);
        end
    endtask
    task tune(input logic [31:0] ctl, input logic [31:0] st);
        hold <= 1'h1;
        wr(8'h20, 32'h1C);
        hold <= 1'h0;
        wr(8'h00, ctl);
        wait_hi(4);
        chk({tune_msg_o, pv_shown_o}, 32'h2);
        wait_hi(5);
        chk({tune_msg_o, pv_shown_o}, 32'h1);
        rd(8'h20);
        chk(d & 32'h1C, st);
        rd(8'h00);
        chk(d, 32'h7);
    endtask

    initial begin
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'h0;
        chk_reset;
        rd(8'h50);
        chk(d, 32'h0);
        chk(r, 32'h2);
        wr(8'h7C, 32'hFFFFFFFF);
        chk(r, 32'h2);
        foreach (rows[k]) begin
            wr(8'h04, {16'h0, rows[k][63:48]});
            wr(8'h08, rows[k][47:16]);
            // The reset period runs a thousand ticks before the first written period is taken.
            repeat (k == 0 ? 10200 : 120) @(posedge mclk_i);
            count_on(20 * rows[k][63:48]);
            chk(c1, 20 * rows[k][15:8]);
            chk(c2, 20 * rows[k][7:0]);
        end
        foreach (ref_rows[k]) begin
            wr(8'h20, 32'h1C);
            wr(8'h00, {16'h0, ref_rows[k]});
            rd(8'h00);
            chk(d, {16'h0, ref_rows[k] & 16'hFFDF});
            rd(8'h20);
            chk(d & 32'h1C, 32'h10);
        end
        // A ten-tick period lets both relay levels give the plant a net slope.
        wr(8'h04, 32'h000A);
        wr(8'h10, 32'h0100);
        wr(8'h08, 32'h01F4);
        wr(8'h0C, 32'h01F4);
        wr(8'h1C, 32'h0);
        wr(8'h18, 32'h0105FC19);
        tune(32'h027, 32'h08);
        rd(8'h08);
        chk(d, 32'h01F4);
        wr(8'h18, 32'h270FFC19);
        tune(32'h227, 32'h04);
        rd(8'h38);
        chk(d, 32'h0);
        tune(32'h047, 32'h04);
        srst_i <= 1'h1;
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'h0;
        chk_reset;
        end_sim;
    end

    task count_on(input int n);
        c1 = 0;
        c2 = 0;
        repeat (n) begin
            @(posedge mclk_i);
            c1 += out1_o;
            c2 += out2_o;
        end
    endtask
endmodule // testbench
